// file: logic/srv_pkg.sv
package srv_pkg;

   localparam int unsigned ADDR_W = 12;
   localparam int unsigned VB_LSB = 7;
   localparam int unsigned VB_W   = 25;
   localparam int unsigned EXC_W  = 5;
   localparam int unsigned PRI_W  = 8;
   localparam int unsigned SYNC_N = 3;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_STATUS    = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_SVB       = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_NSVB      = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_SMSP      = 12'h00C;
   localparam logic [ADDR_W-1:0] OFF_NSMSP     = 12'h010;
   localparam logic [ADDR_W-1:0] OFF_RESET_PC  = 12'h014;
   localparam logic [ADDR_W-1:0] OFF_EXC_TGT   = 12'h018;
   localparam logic [ADDR_W-1:0] OFF_CTRL      = 12'h01C;

   // status, control and pprot field positions
   localparam int unsigned ST_RUN_BIT    = 0;
   localparam int unsigned ST_SEC_BIT    = 1;
   localparam int unsigned ST_PRIV_BIT   = 2;
   localparam int unsigned ST_THREAD_BIT = 3;
   localparam int unsigned CTRL_BOOST_BIT = 0;
   localparam int unsigned PPROT_PRIV_BIT = 0;
   localparam int unsigned PPROT_NS_BIT   = 1;

   // vector table word offsets
   localparam logic [31:0] VEC_SP_OFF = 32'h0000_0000;
   localparam logic [31:0] VEC_PC_OFF = 32'h0000_0004;

   // reset values
   localparam logic [31:0] RST_WORD    = 32'h0000_0000;
   localparam logic [31:0] RST_EXC_TGT = 32'h0000_0000;
   localparam logic [VB_W-1:0] RST_VB  = 25'h000_0000;

   // cycles after reset release before the straps are taken
   localparam logic [2:0] STRAP_WAIT = 3'h4;

   typedef enum logic [3:0] {
      SRV_ST_STRAP = 4'b0001,
      SRV_ST_SP    = 4'b0010,
      SRV_ST_PC    = 4'b0100,
      SRV_ST_RUN   = 4'b1000
   } srv_state_t;

endpackage

// file: logic/srv_sync.sv
`timescale 1ns/1ps
module srv_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,     // clock
   input  wire logic         rst_n,   // async reset, low
   input  wire logic [W-1:0] d,       // asynchronous input
   output logic      [W-1:0] q        // filtered value
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } srv_sync_state_t;

   srv_sync_state_t r;
   srv_sync_state_t next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // s1 feeds only s2; a change counts once s2 and s3 agree
      if (r.s2 == r.s3) begin
         next_r.q = r.s3;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q = r.q;
endmodule

// file: logic/srv_vbase.sv
`timescale 1ns/1ps
module srv_vbase import srv_pkg::*; (
   input  wire logic            clk,        // clock
   input  wire logic            rst_n,      // async reset, low
   input  wire logic            load_strap, // take the reset default
   input  wire logic [VB_W-1:0] strap,      // synchronised default, bits 31:7
   input  wire logic            wr_en,      // software write
   input  wire logic [31:0]     wdata,      // write data
   output logic      [31:0]     base        // table base, 128-byte aligned
);
   typedef struct packed {
      logic [VB_W-1:0] hi;
   } srv_vbase_state_t;

   srv_vbase_state_t r;
   srv_vbase_state_t next_r;

   always_comb begin
      next_r = r;
      if (load_strap) begin
         next_r.hi = strap;
      end else if (wr_en) begin
         next_r.hi = wdata[31:VB_LSB];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r.hi <= RST_VB;
      end else begin
         r <= next_r;
      end
   end

   assign base = {r.hi, 7'h00};
endmodule

// file: logic/srv_reset_entry.sv
`timescale 1ns/1ps
// Notes on behaviour
// - leave reset in secure, privileged, thread state before any instruction
// - fetch first two vector table words as data before instruction fetch
// - both reset vector fetches carry the secure attribute
// - first fetched word becomes the secure main stack pointer
// - second fetched word is the reset handler address; branch there
// - secure vector base defaults from bits 31:7 input, readable by software
// - secure vector base gives the table for secure-target exceptions
// - nonsecure vector base gives the table for nonsecure-target exceptions
// - nonsecure vector base defaults from its own bits 31:7 input
// - secure privileged code selects target state of every exception
// - boost bit ranks secure exceptions above nonsecure ones
module srv_reset_entry import srv_pkg::*; (
   input  wire logic             pclk,       // clock, 20 MHz
   input  wire logic             presetn,    // async reset, low
   input  wire logic             psel,       // apb select
   input  wire logic             penable,    // apb enable
   input  wire logic             pwrite,     // apb direction
   input  wire logic [31:0]      paddr,      // apb address
   input  wire logic [31:0]      pwdata,     // apb write data
   input  wire logic [2:0]       pprot,      // apb protection
   output logic      [31:0]      prdata,     // apb read data
   output logic                  pready,     // apb ready
   output logic                  pslverr,    // apb error
   input  wire logic [VB_W-1:0]  secure_vector_base_reset_input,    // strap pins
   input  wire logic [VB_W-1:0]  nonsecure_vector_base_reset_input, // strap pins
   output logic                  mem_req,    // vector data read request
   output logic      [31:0]      mem_addr,   // read address
   output logic                  mem_secure, // secure attribute
   input  wire logic [31:0]      mem_rdata,  // read data
   input  wire logic             mem_ready,  // read done
   output logic                  core_secure,     // security state
   output logic                  core_privileged, // privilege
   output logic                  core_thread,     // thread mode
   output logic                  insn_fetch_en,   // instruction fetch allowed
   output logic                  branch_valid,    // branch pulse
   output logic      [31:0]      branch_addr,     // branch target
   input  wire logic             exc_valid,       // exception taken pulse
   input  wire logic [EXC_W-1:0] exc_num,         // exception number
   output logic                  exc_vec_valid,   // vector address pulse
   output logic      [31:0]      exc_vec_addr,    // vector entry address
   output logic                  exc_vec_secure,  // target is secure
   input  wire logic             pend_s_valid,    // secure candidate
   input  wire logic [PRI_W-1:0] pend_s_pri,      // its priority, low wins
   input  wire logic             pend_ns_valid,   // nonsecure candidate
   input  wire logic [PRI_W-1:0] pend_ns_pri,     // its priority, low wins
   output logic                  pick_valid,      // arbitration result valid
   output logic                  pick_secure      // secure candidate wins
);
   typedef struct packed {
      srv_state_t  st;
      logic [2:0]  cnt;
      logic        load_strap;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        mem_req;
      logic [31:0] mem_addr;
      logic [31:0] smsp;
      logic [31:0] nsmsp;
      logic [31:0] reset_pc;
      logic [31:0] exc_tgt;
      logic        boost;
      logic        core_secure;
      logic        core_priv;
      logic        core_thread;
      logic        fetch_en;
      logic        branch_valid;
      logic [31:0] branch_addr;
      logic        exc_vec_valid;
      logic [31:0] exc_vec_addr;
      logic        exc_vec_secure;
      logic        pick_valid;
      logic        pick_secure;
   } srv_core_state_t;

   srv_core_state_t r;
   srv_core_state_t next_r;

   logic [VB_W-1:0]   s_strap;
   logic [VB_W-1:0]   ns_strap;
   logic [31:0]       svb;
   logic [31:0]       nsvb;
   logic              setup;
   logic              commit;
   logic              allowed;
   logic [ADDR_W-1:0] off;
   logic              svb_wr;
   logic              nsvb_wr;

   srv_sync #(.W(VB_W)) u_sync_s (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (secure_vector_base_reset_input),
      .q     (s_strap)
   );

   srv_sync #(.W(VB_W)) u_sync_ns (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (nonsecure_vector_base_reset_input),
      .q     (ns_strap)
   );

   srv_vbase u_svb (
      .clk        (pclk),
      .rst_n      (presetn),
      .load_strap (r.load_strap),
      .strap      (s_strap),
      .wr_en      (svb_wr),
      .wdata      (pwdata),
      .base       (svb)
   );

   srv_vbase u_nsvb (
      .clk        (pclk),
      .rst_n      (presetn),
      .load_strap (r.load_strap),
      .strap      (ns_strap),
      .wr_en      (nsvb_wr),
      .wdata      (pwdata),
      .base       (nsvb)
   );

   // only secure privileged software may touch this block
   assign allowed = pprot[PPROT_PRIV_BIT] & ~pprot[PPROT_NS_BIT];
   assign off     = paddr[ADDR_W-1:0];
   assign setup   = psel & ~penable;
   assign commit  = psel & penable & r.pready & ~r.pslverr & pwrite;
   assign svb_wr  = commit & (off == OFF_SVB);
   assign nsvb_wr = commit & (off == OFF_NSVB);

   always_comb begin
      next_r               = r;
      next_r.load_strap    = 1'b0;
      next_r.branch_valid  = 1'b0;
      next_r.exc_vec_valid = 1'b0;
      next_r.pready        = 1'b0;
      next_r.pslverr       = 1'b0;

      case (r.st)
         SRV_ST_STRAP: begin
            // straps need the synchroniser filled before they are taken
            next_r.cnt = r.cnt + 3'h1;
            if (r.cnt == STRAP_WAIT) begin
               next_r.load_strap = 1'b1;
            end
            // leave only once the bases hold the straps, so the first
            // request never goes out with the reset base
            if (r.load_strap) begin
               next_r.st = SRV_ST_SP;
            end
         end
         SRV_ST_SP: begin
            next_r.mem_req  = 1'b1;
            if (!r.mem_req) begin
               // address frozen while the request stands
               next_r.mem_addr = svb + VEC_SP_OFF;
            end
            if (r.mem_req && mem_ready) begin
               next_r.smsp     = mem_rdata;
               next_r.mem_req  = 1'b0;
               next_r.mem_addr = svb + VEC_PC_OFF;
               next_r.st       = SRV_ST_PC;
            end
         end
         SRV_ST_PC: begin
            next_r.mem_req = 1'b1;
            if (r.mem_req && mem_ready) begin
               next_r.reset_pc     = mem_rdata;
               next_r.branch_addr  = mem_rdata;
               next_r.branch_valid = 1'b1;
               next_r.fetch_en     = 1'b1;
               next_r.mem_req      = 1'b0;
               next_r.st           = SRV_ST_RUN;
            end
         end
         SRV_ST_RUN: begin
            // vector words taken; memory port stays idle until next reset
            next_r.mem_req = 1'b0;
         end
         default: begin
            next_r.st = SRV_ST_STRAP;
         end
      endcase

      // exception vector lookup, table chosen by the target state
      if (exc_valid) begin
         next_r.exc_vec_valid  = 1'b1;
         next_r.exc_vec_secure = ~r.exc_tgt[exc_num];
         if (r.exc_tgt[exc_num]) begin
            next_r.exc_vec_addr = nsvb + 32'({exc_num, 2'b00});
         end else begin
            next_r.exc_vec_addr = svb + 32'({exc_num, 2'b00});
         end
      end

      // arbitration between the best secure and nonsecure candidates
      next_r.pick_valid = pend_s_valid | pend_ns_valid;
      if (pend_s_valid && pend_ns_valid) begin
         next_r.pick_secure = r.boost | (pend_s_pri <= pend_ns_pri);
      end else begin
         next_r.pick_secure = pend_s_valid;
      end

      // apb: answer registered in setup, so access phase lasts one cycle
      if (setup) begin
         next_r.pready = 1'b1;
         next_r.prdata = RST_WORD;
         if (!allowed) begin
            next_r.pslverr = 1'b1;
         end else begin
            case (off)
               OFF_STATUS: begin
                  next_r.pslverr                = pwrite;
                  next_r.prdata[ST_RUN_BIT]     = r.fetch_en;
                  next_r.prdata[ST_SEC_BIT]     = r.core_secure;
                  next_r.prdata[ST_PRIV_BIT]    = r.core_priv;
                  next_r.prdata[ST_THREAD_BIT]  = r.core_thread;
               end
               OFF_SVB: begin
                  next_r.prdata = svb;
               end
               OFF_NSVB: begin
                  next_r.prdata = nsvb;
               end
               OFF_SMSP: begin
                  next_r.pslverr = pwrite;
                  next_r.prdata  = r.smsp;
               end
               OFF_NSMSP: begin
                  next_r.prdata = r.nsmsp;
               end
               OFF_RESET_PC: begin
                  next_r.pslverr = pwrite;
                  next_r.prdata  = r.reset_pc;
               end
               OFF_EXC_TGT: begin
                  next_r.prdata = r.exc_tgt;
               end
               OFF_CTRL: begin
                  next_r.prdata[CTRL_BOOST_BIT] = r.boost;
               end
               default: begin
                  next_r.pslverr = 1'b1;
               end
            endcase
         end
      end

      if (commit) begin
         case (off)
            // read-only offsets never get here: pslverr blocks the commit
            OFF_NSMSP: begin
               next_r.nsmsp = pwdata;
            end
            OFF_EXC_TGT: begin
               next_r.exc_tgt = pwdata;
            end
            OFF_CTRL: begin
               next_r.boost = pwdata[CTRL_BOOST_BIT];
            end
            default: begin
               next_r.nsmsp = r.nsmsp;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r                <= '0;
         r.st             <= SRV_ST_STRAP;
         r.exc_tgt        <= RST_EXC_TGT;
         r.core_secure    <= 1'b1;
         r.core_priv      <= 1'b1;
         r.core_thread    <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata          = r.prdata;
   assign pready          = r.pready;
   assign pslverr         = r.pslverr;
   assign mem_req         = r.mem_req;
   assign mem_addr        = r.mem_addr;
   assign mem_secure      = 1'b1;
   assign core_secure     = r.core_secure;
   assign core_privileged = r.core_priv;
   assign core_thread     = r.core_thread;
   assign insn_fetch_en   = r.fetch_en;
   assign branch_valid    = r.branch_valid;
   assign branch_addr     = r.branch_addr;
   assign exc_vec_valid   = r.exc_vec_valid;
   assign exc_vec_addr    = r.exc_vec_addr;
   assign exc_vec_secure  = r.exc_vec_secure;
   assign pick_valid      = r.pick_valid;
   assign pick_secure     = r.pick_secure;
endmodule

// file: verif/srv_mem_model.sv
`timescale 1ns/1ps
module srv_mem_model #(
   parameter logic [31:0] SP_WORD = 32'h0000_0000,
   parameter logic [31:0] PC_WORD = 32'h0000_0000
) (
   input  wire logic        pclk,      // clock
   input  wire logic        presetn,   // reset, low
   input  wire logic [3:0]  lat,       // answer delay
   input  wire logic [31:0] base,      // table base
   input  wire logic        mem_req,   // read request
   input  wire logic [31:0] mem_addr,  // read address
   output logic      [31:0] mem_rdata, // read data
   output logic             mem_ready  // read done
);
   logic [3:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt       <= 4'h0;
         mem_ready <= 1'b0;
         mem_rdata <= 32'h0000_0000;
      end else if (mem_req && !mem_ready && cnt >= lat) begin
         cnt       <= 4'h0;
         mem_ready <= 1'b1;
         if (mem_addr == base)
            mem_rdata <= SP_WORD;
         else if (mem_addr == base + 32'h0000_0004)
            mem_rdata <= PC_WORD;
         else
            mem_rdata <= ~mem_addr;
      end else begin
         cnt       <= (mem_req && !mem_ready) ? cnt + 4'h1 : 4'h0;
         mem_ready <= 1'b0;
         // stale data flips so an early sample cannot pass
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// file: verif/srv_reset_entry_asserts.sv
`timescale 1ns/1ps
module srv_reset_entry_asserts import srv_pkg::*; (
   input wire logic             pclk,            // clk
   input wire logic             presetn,         // rst
   input wire logic             psel,            // sel
   input wire logic             penable,         // en
   input wire logic [2:0]       pprot,           // prot
   input wire logic             pready,          // rdy
   input wire logic             pslverr,         // err
   input wire logic             mem_req,         // req
   input wire logic [31:0]      mem_addr,        // addr
   input wire logic             mem_secure,      // attr
   input wire logic [31:0]      mem_rdata,       // data
   input wire logic             mem_ready,       // done
   input wire logic             core_secure,     // state
   input wire logic             core_privileged, // priv
   input wire logic             core_thread,     // mode
   input wire logic             insn_fetch_en,   // run
   input wire logic             branch_valid,    // br
   input wire logic [31:0]      branch_addr,     // target
   input wire logic             exc_valid,       // exc
   input wire logic [EXC_W-1:0] exc_num,         // num
   input wire logic             exc_vec_valid,   // vec
   input wire logic [31:0]      exc_vec_addr,    // vaddr
   input wire logic             exc_vec_secure,  // vsec
   input wire logic             pend_s_valid,    // s
   input wire logic [PRI_W-1:0] pend_s_pri,      // s pri
   input wire logic             pend_ns_valid,   // ns
   input wire logic [PRI_W-1:0] pend_ns_pri,     // ns pri
   input wire logic             pick_valid,      // pv
   input wire logic             pick_secure      // ps
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   core_state_a: assert property (core_secure && core_privileged && core_thread)
      else $error("core left secure privileged thread");
   fetch_order_a: assert property (mem_req |-> !insn_fetch_en)
      else $error("fetch enabled during vector read");
   secure_attr_a: assert property (mem_req |-> mem_secure)
      else $error("vector read not secure");
   req_hold_a: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr))
      else $error("vector read dropped early");
   second_read_a: assert property (mem_req && mem_ready && mem_addr[6:0] == 7'h00
      |=> !mem_req ##1 mem_req && mem_addr == $past(mem_addr, 2) + 32'h0000_0004)
      else $error("second vector word wrong");
   branch_take_a: assert property (mem_req && mem_ready && mem_addr[6:0] == 7'h04
      |=> branch_valid && insn_fetch_en && branch_addr == $past(mem_rdata))
      else $error("branch not to fetched word");
   vec_entry_a: assert property (exc_valid
      |=> exc_vec_valid && exc_vec_addr[6:0] == {$past(exc_num), 2'b00})
      else $error("vector entry offset wrong");
   apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer timing wrong");
   ns_refused_a: assert property (pready && (pprot[1] || !pprot[0]) |-> pslverr)
      else $error("unsafe access not refused");
   pick_sec_a: assert property (pend_s_valid && pend_ns_valid && pend_s_pri <= pend_ns_pri
      |=> pick_valid && pick_secure)
      else $error("secure candidate lost");
   pick_ns_a: assert property (pend_ns_valid && !pend_s_valid |=> pick_valid && !pick_secure)
      else $error("lone nonsecure lost");
   cover property (branch_valid);
   cover property (pready && pslverr);
   cover property (exc_vec_valid && !exc_vec_secure);
   cover property (pick_secure && pend_s_pri > pend_ns_pri);
endmodule
bind srv_reset_entry srv_reset_entry_asserts chk (.*);

// file: verif/srv_reset_entry_tb_top.sv
`timescale 1ns/1ps
module srv_reset_entry_tb_top import srv_pkg::*; ;
   localparam logic [24:0] S_STRAP = 25'h000_0203;
   localparam logic [24:0] N_STRAP = 25'h000_4005;
   localparam logic [31:0] SVB     = {S_STRAP, 7'h00};
   localparam logic [31:0] NSVB    = {N_STRAP, 7'h00};
   localparam logic [31:0] SP_W    = 32'h0002_1F00;
   localparam logic [31:0] PC_W    = 32'h0001_0401;
   localparam logic [2:0]  P       = 3'b001;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_secure, mem_ready;
   logic core_secure, core_privileged, core_thread, insn_fetch_en, branch_valid;
   logic exc_valid, exc_vec_valid, exc_vec_secure, pend_s_valid, pend_ns_valid;
   logic pick_valid, pick_secure;
   logic [31:0]      paddr, pwdata, prdata, mem_addr, mem_rdata, branch_addr, exc_vec_addr;
   logic [2:0]       pprot;
   logic [3:0]       lat;
   logic [EXC_W-1:0] exc_num;
   logic [PRI_W-1:0] pend_s_pri, pend_ns_pri;
   logic [VB_W-1:0]  secure_vector_base_reset_input, nonsecure_vector_base_reset_input;
   int               n_mismatch, num_checks;

   srv_reset_entry dut (.*);
   srv_mem_model #(.SP_WORD(SP_W), .PC_WORD(PC_W)) mem (.*, .base(SVB));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one idle edge first, so a release and the next setup never collide
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [2:0] p, logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {20'hF_0000, a};
      pwdata  <= d;
      pprot   <= p;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20)
         n_mismatch++;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pslverr", {31'h0, e}, {31'h0, pslverr});
      if (!w)
         chk("prdata", d, prdata);
   endtask

   task automatic boot();
      int n;
      n = 0;
      while (insn_fetch_en !== 1'b1 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      chk("insn_fetch_en", 1, {31'h0, insn_fetch_en});
      chk("branch_addr", PC_W, branch_addr);
   endtask

   task automatic pick(logic sv, logic [7:0] sp, logic nv, logic [7:0] np, logic es);
      pend_s_valid  <= sv;
      pend_s_pri    <= sp;
      pend_ns_valid <= nv;
      pend_ns_pri   <= np;
      @(posedge pclk);
      @(posedge pclk);
      chk("pick_valid", 1, {31'h0, pick_valid});
      chk("pick_secure", {31'h0, es}, {31'h0, pick_secure});
   endtask

   initial begin
      {presetn, psel, penable, pwrite, exc_valid, pend_s_valid, pend_ns_valid} = '0;
      {paddr, pwdata, exc_num, pend_s_pri, pend_ns_pri} = '0;
      pprot = P;
      lat = 4'h3;
      secure_vector_base_reset_input = S_STRAP;
      nonsecure_vector_base_reset_input = N_STRAP;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      boot();
      apb(0, OFF_STATUS, 32'h0000_000F, P, 0);
      apb(0, OFF_SVB, SVB, P, 0);
      apb(0, OFF_NSVB, NSVB, P, 0);
      apb(0, OFF_SMSP, SP_W, P, 0);
      apb(0, OFF_RESET_PC, PC_W, P, 0);
      apb(1, OFF_SMSP, 32'h1234_5678, P, 1);
      apb(0, OFF_SMSP, SP_W, P, 0);
      apb(0, 12'h020, 32'h0000_0000, P, 1);
      apb(0, OFF_SVB, 32'h0000_0000, 3'b011, 1);
      apb(1, OFF_CTRL, 32'h0000_0001, 3'b000, 1);
      $display("test boot done");
      apb(1, OFF_NSVB, 32'h0004_03FF, P, 0);
      apb(0, OFF_NSVB, 32'h0004_0380, P, 0);
      apb(1, OFF_NSMSP, 32'h2020_0400, P, 0);
      apb(0, OFF_NSMSP, 32'h2020_0400, P, 0);
      apb(1, OFF_EXC_TGT, 32'h0000_0008, P, 0);
      apb(0, OFF_EXC_TGT, 32'h0000_0008, P, 0);
      $display("test config done");
      @(posedge pclk);
      exc_valid <= 1'b1;
      exc_num   <= 5'h3;
      @(posedge pclk);
      exc_num   <= 5'h5;
      @(posedge pclk);
      exc_valid <= 1'b0;
      chk("exc_vec_addr", 32'h0004_038C, exc_vec_addr);
      chk("exc_vec_secure", 0, {31'h0, exc_vec_secure});
      @(posedge pclk);
      chk("exc_vec_addr", SVB + 32'h0000_0014, exc_vec_addr);
      chk("exc_vec_secure", 1, {31'h0, exc_vec_secure});
      $display("test vectors done");
      pick(1, 8'h40, 1, 8'h10, 0);
      pick(1, 8'h20, 1, 8'h20, 1);
      pick(0, 8'h00, 1, 8'h30, 0);
      pick(1, 8'hF0, 0, 8'h00, 1);
      apb(1, OFF_CTRL, 32'h0000_0001, P, 0);
      apb(0, OFF_CTRL, 32'h0000_0001, P, 0);
      pick(1, 8'h40, 1, 8'h10, 1);
      $display("test priority done");
      @(posedge pclk);
      presetn <= 1'b0;
      lat     <= 4'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      boot();
      apb(0, OFF_SMSP, SP_W, P, 0);
      apb(0, OFF_NSVB, NSVB, P, 0);
      apb(0, OFF_CTRL, 32'h0000_0000, P, 0);
      $display("test reset done");
      conclude();
   end

   initial begin
      #(50 * 4000);
      n_mismatch++;
      conclude();
   end
endmodule
